// ### core/bshm_pkg.sv
// Constants shared by the board status and health monitor.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone bus.
package bshm_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TICK_MS = 125;
	localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned WD_PERIOD_US = 1000;
	localparam int unsigned WD_CYC = CLK_HZ / 1_000_000 * WD_PERIOD_US;
	localparam logic [3:0] WD_SAMPLES = 4'hA;
	localparam logic [4:0] PULSE_TICKS = 5'h02;
	localparam logic [4:0] GAP_TICKS = 5'h10;
	localparam logic [4:0] SERIAL_RED = 5'h09;
	localparam int unsigned ADR_W = 8;
	localparam logic [7:0] ADR_MODE = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_INT_STAT = 8'h08;
	localparam logic [7:0] ADR_INT_MASK = 8'h0C;
	localparam int unsigned MODE_RATE_LO = 2;
	localparam int unsigned MODE_RED = 4;
	localparam int unsigned MODE_PORT2 = 5;
	localparam int unsigned MODE_CNT_LO = 8;
	localparam logic [15:0] MODE_RST = 16'h0001;
	localparam int unsigned IRQ_W = 4;
	localparam int unsigned IRQ_LOST = 0;
	localparam int unsigned IRQ_GAIN = 1;
	localparam int unsigned IRQ_MISS = 2;
	localparam int unsigned IRQ_SUP = 3;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;
	typedef enum logic [1:0] {K_SOLID = 2'h0, K_FLASH = 2'h1, K_GROUP = 2'h2, K_SERIAL = 2'h3} bshm_kind_t;
	typedef enum logic [1:0] {PS_GAP = 2'b00, PS_ON = 2'b01, PS_OFF = 2'b11} bshm_pst_t;
endpackage : bshm_pkg

// ### core/bshm_top.sv
// Board status and health monitor: bicolour status indicator encoder,
// watchdog and supply health check, Wishbone register slave, interrupt.
// Assumes watchdog, supply-good and firmware-present pins are asynchronous.
// Notes on behaviour
// [RULE_01] Green flashes at 0.25, 0.5, 1 and 2 Hz for download, programming, ready and flash test.
// [RULE_02] Green pulse groups of 1, 2, 3 and 10 show startup and waiting states and passed tests.
// [RULE_03] Red flashes at 0.25, 0.5 and 1 Hz show waiting for the interface, control or adjacent board.
// [RULE_04] Red groups of 2 to 8 pulses report self-test failures and failed loading.
// [RULE_05] A serial port failure shows nine red pulses then one or two green ones for the port.
// [RULE_06] A halted processor after return from the application shows groups of ten red pulses.
// [RULE_07] Programming errors show red groups of 11 to 14 pulses.
// [RULE_08] Running firmware shows solid green.
// [RULE_09] The health indicator goes off after ten consecutive missing watchdog samples.
// [RULE_10] The watchdog arrives every millisecond and is sampled at that period.
// [RULE_11] Any supply-good input other than the 5V rail going low turns the health indicator off.
// [RULE_12] The OK contact follows the health indicator exactly.
// [RULE_13] With no firmware present the indicator shows download mode on its own.
// [RULE_14] Pulses have equal on and off times and each group ends in a longer dark gap.
// [RULE_15] After reset health stays off until ten good watchdog samples and all supplies good; the code does not wait for the 5V rail.
`timescale 1ns/1ps
`default_nettype none
module bshm_top #(
	parameter int unsigned TICK_N = bshm_pkg::TICK_CYC,
	parameter int unsigned WD_N = bshm_pkg::WD_CYC,
	parameter int unsigned SUP_N = 4,
	parameter int unsigned SUP_5V_IDX = 0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [bshm_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic watchdog_i,
	input wire logic [SUP_N-1:0] supply_good_i,
	input wire logic fw_present_i,
	output logic status_green_o,
	output logic status_red_o,
	output logic health_indicator_o,
	output logic controller_ok_contact_o,
	output logic int_o
);
	import bshm_pkg::*;

	function automatic logic [31:0] bshm_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : bshm_merge

	logic ack_q, req, wr, rd;
	logic [31:0] rdat_q, rdat_d, mode_wr, mask_wr;
	logic [15:0] mode_q, mode_eff, mode_prev_q;
	logic [IRQ_W-1:0] int_stat_q, int_mask_q, ev;
	logic int_q;
	logic [31:0] tick_cnt_q, wd_cnt_q;
	logic tick, ms_tick;
	logic [4:0] ph_q, sub_q, idx_q, total;
	bshm_pst_t pst_q, pst_d;
	bshm_kind_t kind;
	logic red_sel, chg, flash_lit, grp_red, grn_d, red_d;
	logic [2:0] wd_s_q;
	logic [1:0] fw_s_q;
	logic [SUP_N-1:0] sup_s1_q, sup_s2_q, sup_5v_mask;
	logic seen_q, sample, wd_ok_q, sup_ok, sup_ok_q, health_q, okc_q, health_d;
	logic [3:0] good_cnt_q, miss_cnt_q;

	// Wishbone: ack one cycle after the request; a write lands on the edge the master sees ack
	assign req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr = wb_cyc_i & wb_stb_i & ack_q & wb_we_i;
	assign rd = req & ~wb_we_i;
	assign mode_wr = bshm_merge({16'h0000, mode_q}, wb_dat_i, wb_sel_i);
	assign mask_wr = bshm_merge({28'h0000000, int_mask_q}, wb_dat_i, wb_sel_i);

	always_comb begin
		rdat_d = 32'h00000000;
		case (wb_adr_i)
			ADR_MODE: rdat_d = {16'h0000, mode_q};
			ADR_STATUS: rdat_d = {20'h00000, miss_cnt_q, good_cnt_q, fw_s_q[1], sup_ok, wd_ok_q, health_q};
			ADR_INT_STAT: rdat_d = {28'h0000000, int_stat_q};
			ADR_INT_MASK: rdat_d = {28'h0000000, int_mask_q};
			default: rdat_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			ack_q <= req;
			if (rd) begin
				rdat_q <= rdat_d;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= MODE_RST;
			int_mask_q <= IRQ_MASK_RST;
		end else if (wr && wb_adr_i == ADR_MODE) begin
			mode_q <= mode_wr[15:0];
		end else if (wr && wb_adr_i == ADR_INT_MASK) begin
			int_mask_q <= mask_wr[IRQ_W-1:0];
		end
	end

	// Time bases: 125 ms indicator tick and 1 ms watchdog sample
	assign tick = (tick_cnt_q == TICK_N - 1);
	assign ms_tick = (wd_cnt_q == WD_N - 1);

	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			tick_cnt_q <= 32'h00000000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h00000001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || ms_tick) begin
			wd_cnt_q <= 32'h00000000; // [RULE_10]
		end else begin
			wd_cnt_q <= wd_cnt_q + 32'h00000001;
		end
	end

	// Pin synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wd_s_q <= 3'h0;
			fw_s_q <= 2'h0;
			sup_s1_q <= '0;
			sup_s2_q <= '0;
		end else begin
			wd_s_q <= {wd_s_q[1:0], watchdog_i};
			fw_s_q <= {fw_s_q[0], fw_present_i};
			sup_s1_q <= supply_good_i;
			sup_s2_q <= sup_s1_q;
		end
	end

	// Missing image forces download mode regardless of software
	assign mode_eff = fw_s_q[1] ? mode_q : MODE_RST; // [RULE_13]
	assign kind = bshm_kind_t'(mode_eff[1:0]);
	assign red_sel = mode_eff[MODE_RED];
	assign chg = (mode_eff != mode_prev_q);
	assign total = (kind == K_SERIAL) ? SERIAL_RED + (mode_eff[MODE_PORT2] ? 5'h02 : 5'h01)
		: {1'b0, mode_eff[MODE_CNT_LO +: 4]};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_prev_q <= MODE_RST;
			ph_q <= 5'h00;
		end else begin
			mode_prev_q <= mode_eff;
			if (chg) begin
				ph_q <= 5'h00;
			end else if (tick) begin
				ph_q <= ph_q + 5'h01;
			end
		end
	end

	// Phase bit 4-rate toggles every 16, 8, 4 or 2 ticks: 0.25 to 2 Hz
	assign flash_lit = ~ph_q[3'd4 - {1'b0, mode_eff[MODE_RATE_LO +: 2]}]; // [RULE_01] [RULE_03]

	// Pulse group sequencer; a gap first keeps the group boundaries readable
	always_comb begin
		pst_d = pst_q;
		case (pst_q)
			PS_GAP: if (tick && sub_q == GAP_TICKS - 5'h01 && total != 5'h00) pst_d = PS_ON;
			PS_ON: if (tick && sub_q == PULSE_TICKS - 5'h01) pst_d = PS_OFF; // [RULE_14]
			PS_OFF: if (tick && sub_q == PULSE_TICKS - 5'h01) pst_d = (idx_q + 5'h01 == total) ? PS_GAP : PS_ON;
			default: pst_d = PS_GAP;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || chg) begin
			pst_q <= PS_GAP;
			sub_q <= 5'h00;
			idx_q <= 5'h00;
		end else if (tick) begin
			pst_q <= pst_d;
			sub_q <= (pst_d != pst_q || sub_q == GAP_TICKS - 5'h01) ? 5'h00 : sub_q + 5'h01;
			if (pst_q == PS_GAP) begin
				idx_q <= 5'h00;
			end else if (pst_q == PS_OFF && pst_d == PS_ON) begin
				idx_q <= idx_q + 5'h01; // [RULE_02] [RULE_04] [RULE_06] [RULE_07]
			end
		end
	end

	// Serial failure: red for the first nine, green for the port number
	assign grp_red = (kind == K_SERIAL) ? (idx_q < SERIAL_RED) : red_sel; // [RULE_05]

	always_comb begin
		grn_d = 1'b0;
		red_d = 1'b0;
		case (kind)
			K_SOLID: begin
				grn_d = ~red_sel; // [RULE_08]
				red_d = red_sel;
			end
			K_FLASH: begin
				grn_d = flash_lit & ~red_sel;
				red_d = flash_lit & red_sel;
			end
			default: begin
				grn_d = (pst_q == PS_ON) & ~grp_red;
				red_d = (pst_q == PS_ON) & grp_red;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_green_o <= 1'b0;
			status_red_o <= 1'b0;
		end else begin
			status_green_o <= grn_d;
			status_red_o <= red_d;
		end
	end

	// Watchdog: any rising edge within the 1 ms window counts as present
	assign sample = seen_q | (wd_s_q[1] & ~wd_s_q[2]);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seen_q <= 1'b0;
			good_cnt_q <= 4'h0;
			miss_cnt_q <= 4'h0;
			wd_ok_q <= 1'b0;
		end else if (ms_tick) begin
			seen_q <= 1'b0;
			good_cnt_q <= sample ? ((good_cnt_q == WD_SAMPLES) ? good_cnt_q : good_cnt_q + 4'h1) : 4'h0;
			miss_cnt_q <= sample ? 4'h0 : ((miss_cnt_q == WD_SAMPLES) ? miss_cnt_q : miss_cnt_q + 4'h1);
			if (sample && good_cnt_q == WD_SAMPLES - 4'h1) begin
				wd_ok_q <= 1'b1; // [RULE_15]
			end else if (!sample && miss_cnt_q == WD_SAMPLES - 4'h1) begin
				wd_ok_q <= 1'b0; // [RULE_09]
			end
		end else begin
			seen_q <= sample;
		end
	end

	// The 5V rail has no bearing on health
	assign sup_5v_mask = SUP_N'(1) << SUP_5V_IDX;
	assign sup_ok = &(sup_s2_q | sup_5v_mask); // [RULE_11]
	assign health_d = wd_ok_q & sup_ok;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			health_q <= 1'b0;
			okc_q <= 1'b0;
			sup_ok_q <= 1'b0;
		end else begin
			health_q <= health_d;
			okc_q <= health_d; // [RULE_12]
			sup_ok_q <= sup_ok;
		end
	end
	assign health_indicator_o = health_q;
	assign controller_ok_contact_o = okc_q;

	// Sticky events; a read clears but a same-cycle event survives
	always_comb begin
		ev = '0;
		ev[IRQ_LOST] = health_q & ~health_d;
		ev[IRQ_GAIN] = ~health_q & health_d;
		ev[IRQ_MISS] = ms_tick & ~sample;
		ev[IRQ_SUP] = sup_ok_q & ~sup_ok;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_stat_q <= '0;
			int_q <= 1'b0;
		end else begin
			int_stat_q <= ((rd && wb_adr_i == ADR_INT_STAT) ? '0 : int_stat_q) | ev;
			int_q <= |(int_stat_q & int_mask_q);
		end
	end
	assign int_o = int_q;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// Counts lit pulses apart from the sequencer index, so a stuck index is caught
	logic [4:0] on_seen_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || chg || (pst_q == PS_GAP && pst_d == PS_GAP)) begin
			on_seen_q <= 5'h00;
		end else if (tick && pst_q != PS_ON && pst_d == PS_ON) begin
			on_seen_q <= on_seen_q + 5'h01;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_ok_follows_health: assert property (controller_ok_contact_o == health_indicator_o) // [RULE_12]
		else $error("ok contact differs from health indicator");
	chk_health_miss_off: assert property (ms_tick && !sample && miss_cnt_q == 4'h9 |-> ##2 !health_indicator_o) // [RULE_09]
		else $error("health still on after ten missed samples");
	chk_health_needs_wd: assert property (health_indicator_o |-> $past(wd_ok_q) && good_cnt_q != 4'h0 || miss_cnt_q != 4'h0) // [RULE_15]
		else $error("health on without good watchdog history");
	chk_supply_drop: assert property (!sup_ok |=> !health_indicator_o) // [RULE_11]
		else $error("health on with a supply low");
	chk_sample_period: assert property (ms_tick |=> !ms_tick) // [RULE_10]
		else $error("watchdog samples back to back");
	chk_no_fw_green: assert property (!fw_s_q[1] [*2] |-> !status_red_o) // [RULE_13]
		else $error("red shown while in forced download");
	chk_solid_green: assert property (kind == K_SOLID && !red_sel && !chg |=> status_green_o && !status_red_o) // [RULE_08]
		else $error("solid green not shown");
	chk_flash_phase: assert property (kind == K_FLASH && !chg |=> (status_green_o | status_red_o) == $past(flash_lit)) // [RULE_01]
		else $error("flash output off its phase");
	chk_group_count: assert property (pst_q == PS_OFF && pst_d == PS_GAP && tick |-> on_seen_q == total) // [RULE_14]
		else $error("pulse group length wrong");
	chk_serial_red: assert property (kind == K_SERIAL && pst_q == PS_ON && idx_q < 5'h09 && !chg |=> status_red_o) // [RULE_05]
		else $error("serial failure pulse not red");
	cov_health_up: cover property (!health_indicator_o ##1 health_indicator_o);
	cov_serial_done: cover property (kind == K_SERIAL && pst_q == PS_OFF && pst_d == PS_GAP && tick);
	cov_irq: cover property (!int_o ##1 int_o);
endmodule : bshm_top
`default_nettype wire

// ### tb/bshm_wd_partner.sv
// Watchdog model of the adjacent control board.
// Assumes one clock; the bench commands stop and slow beating.
`timescale 1ns/1ps
`default_nettype none
module bshm_wd_partner #(
	parameter int unsigned WD_N = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic slow_i,
	output logic watchdog_o
);
	logic [15:0] cnt_q;
	// Slow beats at twice the period, so every other sample misses
	always_ff @(posedge clk_i) begin
		if (rst_i || cnt_q >= 16'((slow_i ? 2 : 1) * WD_N - 1)) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
	assign watchdog_o = run_i && cnt_q < 16'h0002;
endmodule : bshm_wd_partner
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the board status and health monitor.
// Assumes the package, the top module and the watchdog model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import bshm_pkg::*;
	localparam int unsigned TN = 8;
	localparam int unsigned WN = 20;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b1, slow = 1'b0, fw = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] dw = 32'h0, q, rd;
	logic [3:0] sup = 4'hF;
	logic wd, g, r, hl, ok, irq, ack;
	int error_cnt = 0, comparisons = 0, cyc_n = 0, seed = 41742, nr, ng, n, k, c, rb;
	always #12.5 clk_i = ~clk_i;
	bshm_wd_partner #(.WD_N(WN)) wd_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .slow_i(slow), .watchdog_o(wd));
	bshm_top #(.TICK_N(TN), .WD_N(WN)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(rd), .wb_ack_o(ack),
		.watchdog_i(wd), .supply_good_i(sup), .fw_present_i(fw), .status_green_o(g), .status_red_o(r),
		.health_indicator_o(hl), .controller_ok_contact_o(ok), .int_o(irq));
	task automatic tally_and_finish;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [31:0] md(input int kind, input int rate, input int red, input int p2, input int cnt);
		return kind | rate << MODE_RATE_LO | red << MODE_RED | p2 << MODE_PORT2 | cnt << MODE_CNT_LO;
	endfunction : md
	function automatic logic [31:0] exp_grp(input int cnt, input int red);
		return red ? {16'(cnt), 16'h0} : {16'h0, 16'(cnt)};
	endfunction : exp_grp
	function automatic logic lamp(input logic red);
		return red ? r : g;
	endfunction : lamp
	// Called just after a rising edge; holds the request until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	// Cycles between two rising edges of one colour
	task automatic per(input logic red);
		do @(posedge clk_i); while (lamp(red) !== 1'b0);
		do @(posedge clk_i); while (lamp(red) !== 1'b1);
		n = cyc_n;
		do @(posedge clk_i); while (lamp(red) !== 1'b0);
		do @(posedge clk_i); while (lamp(red) !== 1'b1);
		n = cyc_n - n;
	endtask : per
	// A group is framed by dark spells far longer than a pulse off time
	task automatic grp;
		int dark;
		int run_n;
		logic was;
		nr = 0;
		ng = 0;
		dark = 0;
		run_n = 0;
		was = 1'b0;
		while (dark < 100) begin
			@(posedge clk_i);
			dark = (r | g) ? 0 : dark + 1;
		end
		dark = 0;
		while (dark < 100) begin
			@(posedge clk_i);
			if (r | g) begin
				nr += (!was && r) ? 1 : 0;
				ng += (!was && g) ? 1 : 0;
				run_n++;
				dark = 0;
			end else begin
				if (was) chk(32'(run_n), 32'(PULSE_TICKS * TN));
				run_n = 0;
				dark++;
			end
			was = r | g;
		end
	endtask : grp
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (!rst_i) chk({31'h0, ok}, {31'h0, hl});
		if (cyc_n == 60000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({27'h0, g, r, hl, ok, irq}, 32'h0);
		wb(1'b0, ADR_MODE, 32'h0);
		chk(q, 32'(MODE_RST));
		wb(1'b0, ADR_INT_MASK, 32'h0);
		chk(q, 32'(IRQ_MASK_RST));
		wb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h0);
		repeat (5 * WN) @(posedge clk_i);
		chk({31'h0, hl}, 32'h0);
		repeat (10 * WN) @(posedge clk_i);
		chk({31'h0, hl}, 32'h1);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk(q, 32'h000000AF);
		k = 1 + $unsigned($random(seed)) % 3;
		sup[k] <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk({31'h0, hl}, 32'h0);
		sup <= 4'hE;
		repeat (12 * WN) @(posedge clk_i);
		chk({31'h0, hl}, 32'h1);
		sup <= 4'hF;
		wb(1'b1, ADR_INT_MASK, 32'h1 << IRQ_LOST);
		wb(1'b0, ADR_INT_STAT, 32'h0);
		chk(q, 32'h0000000B);
		slow <= 1'b1;
		repeat (30 * WN) @(posedge clk_i);
		chk({30'h0, hl, irq}, 32'h2);
		slow <= 1'b0;
		repeat (3 * WN) @(posedge clk_i);
		run <= 1'b0;
		repeat (8 * WN) @(posedge clk_i);
		chk({30'h0, hl, irq}, 32'h2);
		repeat (4 * WN) @(posedge clk_i);
		chk({30'h0, hl, irq}, 32'h1);
		wb(1'b0, ADR_INT_STAT, 32'h0);
		chk(q, 32'h00000005);
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		run <= 1'b1;
		for (k = 0; k < 8; k++) begin
			wb(1'b1, ADR_MODE, md(1, k % 4, k / 4, 0, 0));
			wb(1'b0, ADR_MODE, 32'h0);
			chk(q, md(1, k % 4, k / 4, 0, 0));
			per(k[2]);
			chk(32'(n), 32'(2 * (16 >> (k % 4)) * TN));
		end
		for (k = 0; k < 28; k++) begin
			c = 1 + k % 14;
			rb = k / 14;
			wb(1'b1, ADR_MODE, md(2, 0, rb, 0, c));
			grp();
			chk({nr[15:0], ng[15:0]}, exp_grp(c, rb));
		end
		for (k = 0; k < 2; k++) begin
			wb(1'b1, ADR_MODE, md(3, 0, 0, k, 0));
			grp();
			chk({nr[15:0], ng[15:0]}, {16'(SERIAL_RED), 16'(k + 1)});
		end
		wb(1'b1, ADR_MODE, md(0, 0, 0, 0, 0));
		repeat (2) @(posedge clk_i);
		repeat (300) begin
			@(posedge clk_i);
			chk({30'h0, g, r}, 32'h2);
		end
		fw <= 1'b0;
		per(1'b0);
		chk(32'(n), 32'(32 * TN));
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
